/* File: beam_group_modcomp_ext_framer_test.sv */
// self-checking bench for the extension framer with apb tasks
`timescale 1ns/10ps

module beam_group_modcomp_ext_framer_test;
	import bgf_pkg::*;

	logic        clk;
	logic        rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        byte_valid;
	logic        byte_ready;
	logic [7:0]  byte_data;
	logic        byte_last;
	logic        slow;
	int          failures;
	int          comparisons;
	int          cycles;
	logic [31:0] rd;
	logic        err;
	logic [14:0] ids[3];
	logic [27:0] sets[4];
	logic [7:0]  exp_q[$];

	bgf_framer i_dut (
		.i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .o_byte_valid(byte_valid),
		.i_byte_ready(byte_ready), .o_byte_data(byte_data), .o_byte_last(byte_last)
	);

	bgf_ru_model i_ru (
		.i_clk(clk), .i_rst(rst), .i_slow(slow), .i_valid(byte_valid),
		.i_data(byte_data), .i_last(byte_last), .o_ready(byte_ready)
	);

	// ----------------------------------------------------------------
	// clock, timeout and verdict
	// ----------------------------------------------------------------
	always #4 clk = ~clk;

	// a run needs well under a thousand cycles, so this only trips on a hang
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			finish_test();
		end
	end

	task automatic finish_test();
		if (failures == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : finish_test

	task automatic check_value(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check_value

	// ----------------------------------------------------------------
	// apb master: setup, access until pready, then release
	// ----------------------------------------------------------------
	task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb_xfer

	task automatic reg_check(input string name, input logic [7:0] a, input logic [31:0] exp);
		apb_xfer(1'b0, a, 32'h0000_0000);
		check_value(name, rd, exp);
	endtask : reg_check

	// expected section from the field layout; padding octets are zero
	task automatic build_exp(input logic per);
		logic [55:0] pair;
		logic [31:0] one;
		exp_q = {8'h8a, 8'h03, 8'h83};
		for (int k = 0; k < 3; k++) begin
			exp_q.push_back({1'b0, ids[k][14:8]});
			exp_q.push_back(ids[k][7:0]);
		end
		exp_q = {exp_q, 8'h00, 8'h00, 8'h00};
		if (!per) begin
			pair = {sets[0], sets[1]};
			exp_q = {exp_q, 8'h05, 8'h03};
			for (int j = 6; j >= 0; j--) exp_q.push_back(pair[j*8 +: 8]);
			exp_q = {exp_q, 8'h00, 8'h00, 8'h00};
		end else begin
			for (int s = 0; s < 4; s++) begin
				one = {sets[s], 4'h0};
				exp_q.push_back((s == 3) ? 8'h05 : 8'h85);
				exp_q.push_back(8'h02);
				for (int j = 3; j >= 0; j--) exp_q.push_back(one[j*8 +: 8]);
				exp_q = {exp_q, 8'h00, 8'h00};
			end
		end
	endtask : build_exp

	// waits for the whole section, then checks every octet and the end marker
	task automatic frame_check(input logic per);
		build_exp(per);
		while (i_ru.rx_q.size() < exp_q.size()) @(posedge clk);
		repeat (6) @(posedge clk);
		check_value("octet count", i_ru.rx_q.size(), exp_q.size());
		check_value("valid after end", byte_valid, 1'b0);
		check_value("model last", i_ru.seen_last, 1'b1);
		for (int i = 0; i < exp_q.size(); i++) begin
			check_value("octet", i_ru.rx_q[i][7:0], exp_q[i]);
			check_value("last", i_ru.rx_q[i][8], i == exp_q.size() - 1);
		end
		i_ru.rx_q.delete();
	endtask : frame_check

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		slow = 1'b1;
		failures = 0;
		comparisons = 0;
		cycles = 0;
		ids = '{15'h7fff, 15'h0001, 15'h4321};
		sets = '{28'hfff_8000, 28'h0a5_7ffe, 28'h123_4567, 28'h801_0001};
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		reg_check("ctrl reset", ADDR_CTRL, 32'h0000_0000);
		reg_check("status reset", ADDR_STATUS, 32'h0000_0000);
		reg_check("port reset", ADDR_PORT_ID0, 32'h0000_0000);
		reg_check("unmapped", 8'h24, 32'h0000_0000);
		check_value("unmapped error", err, 1'b1);
		apb_xfer(1'b1, ADDR_STATUS, 32'hffff_ffff);
		reg_check("status read only", ADDR_STATUS, 32'h0000_0000);
		// upper bits written high must read back as zero
		apb_xfer(1'b1, ADDR_PORT_ID0, 32'hffff_ffff);
		for (int k = 1; k < 3; k++) apb_xfer(1'b1, ADDR_PORT_ID0 + 8'(4*k), {17'h1ffff, ids[k]});
		for (int k = 0; k < 4; k++) apb_xfer(1'b1, ADDR_SCALER0 + 8'(4*k), {4'hf, sets[k]});
		for (int k = 0; k < 3; k++) reg_check("port id", ADDR_PORT_ID0 + 8'(4*k), {17'h0, ids[k]});
		for (int k = 0; k < 4; k++) reg_check("scaler", ADDR_SCALER0 + 8'(4*k), {4'h0, sets[k]});
		// shared layout with a stalling consumer; config writes while busy are dropped
		apb_xfer(1'b1, ADDR_CTRL, 32'h0000_0001);
		apb_xfer(1'b0, ADDR_STATUS, 32'h0000_0000);
		check_value("busy", rd[0], 1'b1);
		apb_xfer(1'b1, ADDR_CTRL, 32'h0000_0003);
		apb_xfer(1'b1, ADDR_PORT_ID0, 32'h0000_1111);
		frame_check(1'b0);
		reg_check("port frozen", ADDR_PORT_ID0, 32'h0000_7fff);
		reg_check("ctrl after shared", ADDR_CTRL, 32'h0000_0000);
		apb_xfer(1'b0, ADDR_STATUS, 32'h0000_0000);
		check_value("status one", rd, 32'h0000_0100);
		// per-stream layout, consumer always ready
		slow <= 1'b0;
		apb_xfer(1'b1, ADDR_CTRL, 32'h0000_0002);
		reg_check("ctrl mode", ADDR_CTRL, 32'h0000_0002);
		apb_xfer(1'b1, ADDR_CTRL, 32'h0000_0003);
		frame_check(1'b1);
		apb_xfer(1'b0, ADDR_STATUS, 32'h0000_0000);
		check_value("status two", rd, 32'h0000_0200);
		finish_test();
	end
endmodule : beam_group_modcomp_ext_framer_test

/* File: bgf_fifo.sv */
// constants package and the small word fifo that buffers the framed byte stream
`timescale 1ns/10ps

package bgf_pkg;
	// ----------------------------------------------------------------
	// register map (byte addresses on the apb bus)
	// ----------------------------------------------------------------
	localparam logic [7:0]  ADDR_CTRL      = 8'h00;
	localparam logic [7:0]  ADDR_STATUS    = 8'h04;
	localparam logic [7:0]  ADDR_PORT_ID0  = 8'h08;  // second, third, fourth port at +4 steps
	localparam logic [7:0]  ADDR_SCALER0   = 8'h14;  // scaler sets 0..3 at +4 steps
	localparam int          NUM_EXTRA_PORTS = 3;
	localparam int          NUM_SCALERS     = 4;
	// field positions
	localparam int          CTRL_START_BIT = 0;
	localparam int          CTRL_PER_BIT   = 1;
	localparam int          STAT_BUSY_BIT  = 0;
	localparam int          STAT_IDX_LSB   = 16;
	localparam int          STAT_CNT_LSB   = 8;
	localparam int          ID_WIDTH       = 15;
	localparam int          SET_WIDTH      = 28;     // mask 12, shift flag 1, offset 15
	// reset values
	localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
	localparam logic [14:0] ID_RESET       = 15'h0000;
	localparam logic [27:0] SET_RESET      = 28'h000_0000;
	// extension field codes
	localparam logic [6:0]  EXT_TYPE_BEAM  = 7'h0a;
	localparam logic [6:0]  EXT_TYPE_MOD   = 7'h05;
	localparam logic [7:0]  BEAM_WORDS     = 8'h03;
	localparam logic [7:0]  SHARED_WORDS   = 8'h03;
	localparam logic [7:0]  PER_WORDS      = 8'h02;
	localparam logic [1:0]  GROUP_TYPE     = 2'b10;
	localparam logic [5:0]  EXTRA_PORTS    = 6'h03;
	// frame geometry in octets
	localparam logic [5:0]  BEAM_BYTES     = 6'h0c;
	localparam logic [5:0]  SHARED_LAST    = 6'h17;  // 24 octets in the shared layout
	localparam logic [5:0]  PER_LAST       = 6'h2b;  // 44 octets in the per-stream layout
	localparam int          FIFO_DEPTH     = 4;
	localparam int          FIFO_WIDTH     = 9;      // last marker and octet
endpackage : bgf_pkg

module bgf_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	input  wire logic             i_clk,       // system clock
	input  wire logic             i_rst,       // synchronous reset, active high
	input  wire logic             i_in_valid,  // writer offers a word
	output logic                  o_in_ready,  // room for a word
	input  wire logic [WIDTH-1:0] i_in_data,   // word to store
	output logic                  o_out_valid, // a word is waiting
	input  wire logic             i_out_ready, // reader takes the word
	output logic      [WIDTH-1:0] o_out_data   // oldest word
);
	import bgf_pkg::*;

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// ----------------------------------------------------------------
	// elaboration check
	// ----------------------------------------------------------------
	// pointer wrap relies on a power-of-two depth
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_param
		$error("bgf_fifo depth must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0]      wr_ptr_reg;
	logic [AW:0]      rd_ptr_reg;
	logic             full;
	logic             empty;

	// extra pointer bit tells full from empty
	assign empty = (wr_ptr_reg == rd_ptr_reg);
	assign full  = (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]) && (wr_ptr_reg[AW] != rd_ptr_reg[AW]);
	assign o_in_ready  = !full;
	assign o_out_valid = !empty;
	assign o_out_data  = mem_reg[rd_ptr_reg[AW-1:0]];

	// write side
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wr_ptr_reg <= '0;
		end else if (i_in_valid && !full) begin
			mem_reg[wr_ptr_reg[AW-1:0]] <= i_in_data;
			wr_ptr_reg                  <= wr_ptr_reg + 1'b1;
		end
	end

	// read side
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rd_ptr_reg <= '0;
		end else if (i_out_ready && !empty) begin
			rd_ptr_reg <= rd_ptr_reg + 1'b1;
		end
	end
endmodule : bgf_fifo

/* File: bgf_framer.sv */
// framer that emits the beam-grouping and modulation-compression extensions
`timescale 1ns/10ps

module bgf_framer #(
	parameter int FIFO_DEPTH_P = bgf_pkg::FIFO_DEPTH
) (
	input  wire logic        i_clk,          // 125 mhz system clock
	input  wire logic        i_rst,          // synchronous reset, active high
	input  wire logic        i_psel,         // apb select
	input  wire logic        i_penable,      // apb access phase
	input  wire logic        i_pwrite,       // apb write when high
	input  wire logic [7:0]  i_paddr,        // apb byte address
	input  wire logic [31:0] i_pwdata,       // apb write data
	output logic      [31:0] o_prdata,       // apb read data
	output logic             o_pready,       // apb ready, no wait states
	output logic             o_pslverr,      // apb error on unmapped address
	output logic             o_byte_valid,   // framed octet available
	input  wire logic        i_byte_ready,   // downstream takes the octet
	output logic      [7:0]  o_byte_data,    // framed octet
	output logic             o_byte_last     // last octet of the section extensions
);
	import bgf_pkg::*;

	// ----------------------------------------------------------------
	// elaboration check
	// ----------------------------------------------------------------
	if (FIFO_DEPTH_P < 2) begin : g_bad_depth
		$error("bgf_framer needs a fifo depth of at least 2");
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_SEND = 2'b10
	} bgf_state_type;

	bgf_state_type         state_reg;
	logic                  per_stream_reg;
	logic [ID_WIDTH-1:0]   port_id_reg [NUM_EXTRA_PORTS];
	logic [SET_WIDTH-1:0]  scaler_reg  [NUM_SCALERS];
	logic [5:0]            idx_reg;
	logic [7:0]            frame_cnt_reg;
	logic [31:0]           prdata_reg;

	logic                  busy;
	logic                  wr_access;
	logic                  setup_read;
	logic                  addr_hit;
	logic                  start_req;
	logic                  push;
	logic                  push_ready;
	logic                  push_last;
	logic [7:0]            push_data;
	logic [5:0]            last_idx;
	logic [5:0]            rel;
	logic [3:0]            shared_k;
	logic [1:0]            per_k;
	logic [1:0]            per_sel;
	logic [55:0]           shared_bits;
	logic [55:0]           shared_shift;
	logic [31:0]           per_word;
	logic [31:0]           per_shift;
	logic [31:0]           read_mux;
	logic [FIFO_WIDTH-1:0] fifo_out;

	assign busy      = (state_reg == ST_SEND);
	assign wr_access = i_psel && i_penable && i_pwrite;
	assign setup_read = i_psel && !i_penable && !i_pwrite;

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	// decode: control, status, three port ids, four scaler sets
	always_comb begin
		addr_hit = 1'b0;
		read_mux = 32'h0000_0000;
		if (i_paddr == ADDR_CTRL) begin
			addr_hit = 1'b1;
			read_mux[CTRL_PER_BIT] = per_stream_reg;
		end else if (i_paddr == ADDR_STATUS) begin
			addr_hit = 1'b1;
			read_mux[STAT_BUSY_BIT] = busy;
			read_mux[STAT_CNT_LSB +: 8] = frame_cnt_reg;
			read_mux[STAT_IDX_LSB +: 6] = idx_reg;
		end
		for (int p = 0; p < NUM_EXTRA_PORTS; p++) begin
			if (i_paddr == ADDR_PORT_ID0 + 8'(4 * p)) begin
				addr_hit = 1'b1;
				read_mux[ID_WIDTH-1:0] = port_id_reg[p];
			end
		end
		for (int s = 0; s < NUM_SCALERS; s++) begin
			if (i_paddr == ADDR_SCALER0 + 8'(4 * s)) begin
				addr_hit = 1'b1;
				read_mux[SET_WIDTH-1:0] = scaler_reg[s];
			end
		end
	end

	// zero wait states; an unmapped address answers with an error
	assign o_pready  = 1'b1;
	assign o_pslverr = i_psel && i_penable && !addr_hit;
	assign o_prdata  = prdata_reg;

	// read data is captured in the setup cycle so it comes from a flop
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			prdata_reg <= 32'h0000_0000;
		end else if (setup_read) begin
			prdata_reg <= read_mux;
		end
	end

	// configuration is frozen while a section is being sent, so a frame
	// never mixes old and new identifiers
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			per_stream_reg <= CTRL_RESET[CTRL_PER_BIT];
		end else if (wr_access && !busy && i_paddr == ADDR_CTRL) begin
			per_stream_reg <= i_pwdata[CTRL_PER_BIT];
		end
	end

	// port identifier and scaler set storage, one register per entry
	for (genvar p = 0; p < NUM_EXTRA_PORTS; p++) begin : g_port
		always_ff @(posedge i_clk) begin
			if (i_rst) begin
				port_id_reg[p] <= ID_RESET;
			end else if (wr_access && !busy && i_paddr == ADDR_PORT_ID0 + 8'(4 * p)) begin
				port_id_reg[p] <= i_pwdata[ID_WIDTH-1:0];
			end
		end
	end

	for (genvar s = 0; s < NUM_SCALERS; s++) begin : g_scaler
		always_ff @(posedge i_clk) begin
			if (i_rst) begin
				scaler_reg[s] <= SET_RESET;
			end else if (wr_access && !busy && i_paddr == ADDR_SCALER0 + 8'(4 * s)) begin
				scaler_reg[s] <= i_pwdata[SET_WIDTH-1:0];
			end
		end
	end

	// a start request while busy is dropped
	assign start_req = wr_access && !busy && i_paddr == ADDR_CTRL && i_pwdata[CTRL_START_BIT];

	// ----------------------------------------------------------------
	// octet sequencer
	// ----------------------------------------------------------------
	assign last_idx   = per_stream_reg ? PER_LAST : SHARED_LAST;
	assign push       = busy && push_ready;
	assign push_last  = (idx_reg == last_idx);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_reg <= ST_IDLE;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (start_req) begin
						state_reg <= ST_SEND;
					end
				end
				ST_SEND: begin
					if (push && push_last) begin
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// octet index walks through the section, stalled by fifo back-pressure
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			idx_reg <= 6'h00;
		end else if (start_req) begin
			idx_reg <= 6'h00;
		end else if (push) begin
			idx_reg <= push_last ? 6'h00 : idx_reg + 6'h01;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			frame_cnt_reg <= 8'h00;
		end else if (push && push_last) begin
			frame_cnt_reg <= frame_cnt_reg + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// octet content
	// ----------------------------------------------------------------
	// both shared scaler sets laid end to end, most significant bit first
	assign shared_bits = {scaler_reg[0], scaler_reg[1]};
	assign rel         = idx_reg - BEAM_BYTES;
	assign shared_k    = rel[3:0] - 4'h2;
	assign per_sel     = rel[4:3];
	assign per_k       = rel[1:0] - 2'h2;
	assign per_word    = {scaler_reg[per_sel], 4'h0};
	assign shared_shift = shared_bits << {shared_k, 3'b000};
	assign per_shift    = per_word << {per_k, 3'b000};

	always_comb begin
		push_data = 8'h00;  // padding octets default to zero
		if (idx_reg < BEAM_BYTES) begin
			unique case (idx_reg)
				6'h00: push_data = {1'b1, EXT_TYPE_BEAM};
				6'h01: push_data = BEAM_WORDS;
				6'h02: push_data = {GROUP_TYPE, EXTRA_PORTS};
				6'h03: push_data = {1'b0, port_id_reg[0][14:8]};
				6'h04: push_data = port_id_reg[0][7:0];
				6'h05: push_data = {1'b0, port_id_reg[1][14:8]};
				6'h06: push_data = port_id_reg[1][7:0];
				6'h07: push_data = {1'b0, port_id_reg[2][14:8]};
				6'h08: push_data = port_id_reg[2][7:0];
				default: push_data = 8'h00;
			endcase
		end else if (!per_stream_reg) begin
			// one shared extension closes the section
			if (rel == 6'h00) begin
				push_data = {1'b0, EXT_TYPE_MOD};
			end else if (rel == 6'h01) begin
				push_data = SHARED_WORDS;
			end else if (rel < 6'h09) begin
				push_data = shared_shift[55:48];
			end
		end else begin
			// four extensions of two words; only the fourth clears the flag
			if (rel[2:0] == 3'h0) begin
				push_data = {(per_sel != 2'h3), EXT_TYPE_MOD};
			end else if (rel[2:0] == 3'h1) begin
				push_data = PER_WORDS;
			end else if (rel[2:0] < 3'h6) begin
				push_data = per_shift[31:24];
			end
		end
	end

	// ----------------------------------------------------------------
	// output buffer
	// ----------------------------------------------------------------
	bgf_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH_P)
	) u_fifo (
		.i_clk       (i_clk),
		.i_rst       (i_rst),
		.i_in_valid  (busy),
		.o_in_ready  (push_ready),
		.i_in_data   ({push_last, push_data}),
		.o_out_valid (o_byte_valid),
		.i_out_ready (i_byte_ready),
		.o_out_data  (fifo_out)
	);

	assign o_byte_last = fifo_out[8];
	assign o_byte_data = fifo_out[7:0];

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sequence s_push_at(int n);
		push && idx_reg == 6'(n);
	endsequence

	sequence s_beam_head;
		s_push_at(0) ##[1:9] s_push_at(1);
	endsequence

	property p_beam_hdr;
		@(posedge i_clk) disable iff (i_rst)
		s_push_at(0) |-> push_data == 8'h8a;
	endproperty
	a_beam_hdr: assert property (p_beam_hdr) else $error("beam header octet wrong");

	property p_beam_len;
		@(posedge i_clk) disable iff (i_rst)
		s_beam_head |-> push_data == 8'h03;
	endproperty
	a_beam_len: assert property (p_beam_len) else $error("beam length wrong");

	property p_port_count;
		@(posedge i_clk) disable iff (i_rst)
		s_push_at(2) |-> push_data == 8'h83;
	endproperty
	a_port_count: assert property (p_port_count) else $error("group type or port count wrong");

	property p_port_id;
		@(posedge i_clk) disable iff (i_rst)
		s_push_at(7) |-> push_data == {1'b0, port_id_reg[2][14:8]};
	endproperty
	a_port_id: assert property (p_port_id) else $error("port identifier octet wrong");

	property p_shared_hdr;
		@(posedge i_clk) disable iff (i_rst)
		(s_push_at(12) ##0 !per_stream_reg) |-> push_data == 8'h05 && last_idx == 6'h17;
	endproperty
	a_shared_hdr: assert property (p_shared_hdr) else $error("shared header wrong");

	property p_shared_len;
		@(posedge i_clk) disable iff (i_rst)
		(s_push_at(13) ##0 !per_stream_reg) |-> push_data == 8'h03;
	endproperty
	a_shared_len: assert property (p_shared_len) else $error("shared length wrong");

	property p_shared_pack;
		@(posedge i_clk) disable iff (i_rst)
		(s_push_at(17) ##0 !per_stream_reg) |->
			push_data == {scaler_reg[0][3:0], scaler_reg[1][27:24]};
	endproperty
	a_shared_pack: assert property (p_shared_pack) else $error("scaler sets not packed");

	property p_per_hdr;
		@(posedge i_clk) disable iff (i_rst)
		(s_push_at(28) ##0 per_stream_reg) |-> push_data == 8'h85 && last_idx == 6'h2b;
	endproperty
	a_per_hdr: assert property (p_per_hdr) else $error("per-stream header wrong");

	property p_per_last;
		@(posedge i_clk) disable iff (i_rst)
		(s_push_at(36) ##0 per_stream_reg) |-> push_data == 8'h05;
	endproperty
	a_per_last: assert property (p_per_last) else $error("last flag not cleared");

	property p_per_set;
		@(posedge i_clk) disable iff (i_rst)
		(s_push_at(21) ##0 per_stream_reg) |-> push_data == 8'h02;
	endproperty
	a_per_set: assert property (p_per_set) else $error("per-stream length wrong");

	// last data octet of a single set carries the offset tail and zero fill
	property p_per_data;
		@(posedge i_clk) disable iff (i_rst)
		(s_push_at(25) ##0 per_stream_reg) |-> push_data == {scaler_reg[1][3:0], 4'h0};
	endproperty
	a_per_data: assert property (p_per_data) else $error("per-stream set wrong");

	property p_pad;
		@(posedge i_clk) disable iff (i_rst)
		(s_push_at(9) or s_push_at(10) or s_push_at(11)) |-> push_data == 8'h00;
	endproperty
	a_pad: assert property (p_pad) else $error("padding not zero");

	property p_frame_end;
		@(posedge i_clk) disable iff (i_rst)
		(push && push_last) |=> state_reg == ST_IDLE && idx_reg == 6'h00;
	endproperty
	a_frame_end: assert property (p_frame_end) else $error("frame did not end");
endmodule : bgf_framer

/* File: bgf_ru_model.sv */
// radio unit side model that consumes the framed octet stream
`timescale 1ns/10ps

module bgf_ru_model (
	input  wire logic       i_clk,   // system clock
	input  wire logic       i_rst,   // synchronous reset, active high
	input  wire logic       i_slow,  // take one octet in eight cycles when high
	input  wire logic       i_valid, // octet offered
	input  wire logic [7:0] i_data,  // offered octet
	input  wire logic       i_last,  // final octet of the section
	output logic            o_ready  // model takes the octet
);
	// ----------------------------------------------------------------
	// pacing and capture
	// ----------------------------------------------------------------
	logic [2:0] pace_reg;
	logic [8:0] rx_q[$];
	logic       seen_last;

	// slow pacing lets the fifo fill so the sequencer has to stall
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			pace_reg <= 3'h0;
		end else begin
			pace_reg <= pace_reg + 3'h1;
		end
	end

	assign o_ready = !i_rst && (!i_slow || pace_reg == 3'h7);

	// every accepted octet is kept, padding too, so the bench can judge it
	always @(posedge i_clk) begin
		if (!i_rst && i_valid && o_ready) begin
			rx_q.push_back({i_last, i_data});
			seen_last <= i_last;
		end
	end
endmodule : bgf_ru_model
